// ### design/coax_cfg_pkg.sv
`default_nettype none
package coax_cfg_pkg;
   // Register map
   localparam logic [7:0] ADDR_CHIP_RESET = 8'h00;
   localparam logic [7:0] ADDR_LINK_CONFIG = 8'h01;
   localparam logic [7:0] ADDR_UPLINK_RATE = 8'h0A;
   localparam logic [7:0] ADDR_DOWNLINK_RATE = 8'h14;
   // Field positions
   localparam int BIT_SOFT_RESET = 0;
   localparam int BIT_REVISION_LO = 5;
   localparam int BIT_CFG_SOURCE = 0;
   localparam int BIT_ROLE = 1;
   localparam int BIT_PORT_LO = 3;
   localparam int BIT_MII = 5;
   localparam int BIT_REFCLK_EXT = 6;
   // Values after reset and writable masks
   localparam logic [7:0] LINK_CONFIG_RESET = 8'h60;
   localparam logic [7:0] LINK_CONFIG_MASK = 8'h7B;
   localparam logic [4:0] UPLINK_RATE_RESET = 5'h00;
   localparam logic [4:0] DOWNLINK_RATE_RESET = 5'h00;
   // Uplink rate codes
   localparam logic [4:0] RATE_UP_3M = 5'h02;
   localparam logic [4:0] RATE_UP_4M = 5'h04;
   localparam logic [4:0] RATE_UP_9M = 5'h11;
   localparam logic [4:0] RATE_UP_11M = 5'h13;
   // Port arrangement codes
   localparam logic [1:0] PORT_A_MAC = 2'h0;
   localparam logic [1:0] PORT_B_PHY = 2'h1;
   localparam logic [1:0] PORT_PASSTHROUGH = 2'h2;
   // Soft reset duration
   localparam int CLK_PERIOD_NS = 8;
   localparam int SOFT_RESET_NS = 1000;
   localparam int SOFT_RESET_CYCLES = (SOFT_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [7:0] SOFT_RESET_COUNT = 8'(SOFT_RESET_CYCLES);
   // Control port
   localparam logic [6:0] DEFAULT_DEVICE_ADDR = 7'h2C;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [3:0] MASTER_ACK_SLOT = 4'h9;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ADDR,
      ST_PTR,
      ST_WDATA,
      ST_RDATA
   } ctrl_state_t;
endpackage : coax_cfg_pkg
`default_nettype wire

// ### design/control_port_slave.sv
`timescale 1ns/100ps
`default_nettype none
module control_port_slave
   import coax_cfg_pkg::*;
(
   input wire logic core_clk,         // Core clock
   input wire logic rst_sync_n,       // Synchronised reset
   input wire logic [6:0] dev_addr,   // Bus address of this device
   input wire logic scl_in,           // Serial clock pin level
   input wire logic sda_in,           // Serial data pin level
   output logic sda_out,              // Serial data drive value
   output logic sda_oe,               // High while pulling data low
   output logic reg_wr,               // One-cycle write strobe
   output logic [7:0] reg_addr,       // Register pointer
   output logic [7:0] reg_wdata,      // Write data
   input wire logic [7:0] reg_rdata   // Read data at pointer
);
   logic [2:0] scl_sync;
   logic [2:0] sda_sync;
   logic scl_f;
   logic sda_f;
   logic scl_q;
   logic sda_q;
   logic scl_rise;
   logic scl_fall;
   logic start_seen;
   logic stop_seen;
   ctrl_state_t state;
   logic [3:0] bit_cnt;
   logic [7:0] shift;
   logic ack_on;
   logic rw_read;

   assign sda_out = 1'b0;

   // Three-stage sampling, level accepted once the last two agree
   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         scl_sync <= 3'h7;
         sda_sync <= 3'h7;
         scl_f <= 1'b1;
         sda_f <= 1'b1;
      end else begin
         scl_sync <= {scl_sync[1:0], scl_in};
         sda_sync <= {sda_sync[1:0], sda_in};
         if (scl_sync[1] == scl_sync[2]) scl_f <= scl_sync[2];
         if (sda_sync[1] == sda_sync[2]) sda_f <= sda_sync[2];
      end
   end

   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= scl_f;
         sda_q <= sda_f;
      end
   end

   assign scl_rise = scl_f & ~scl_q;
   assign scl_fall = ~scl_f & scl_q;
   assign start_seen = scl_f & scl_q & sda_q & ~sda_f;
   assign stop_seen = scl_f & scl_q & ~sda_q & sda_f;

   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         state <= ST_IDLE;
         bit_cnt <= 4'h0;
         shift <= 8'h00;
         ack_on <= 1'b0;
         rw_read <= 1'b0;
         sda_oe <= 1'b0;
         reg_wr <= 1'b0;
         reg_addr <= 8'h00;
         reg_wdata <= 8'h00;
      end else begin
         reg_wr <= 1'b0;
         if (start_seen) begin
            state <= ST_ADDR;
            bit_cnt <= 4'h0;
            ack_on <= 1'b0;
            sda_oe <= 1'b0;
         end else if (stop_seen) begin
            state <= ST_IDLE;
            ack_on <= 1'b0;
            sda_oe <= 1'b0;
         end else if (state == ST_RDATA) begin
            if (scl_rise) begin
               if (bit_cnt < BITS_PER_BYTE) begin
                  bit_cnt <= bit_cnt + 4'h1;
               end else if (sda_f) begin
                  state <= ST_IDLE;
               end else begin
                  bit_cnt <= MASTER_ACK_SLOT;
               end
            end else if (scl_fall) begin
               if (bit_cnt == BITS_PER_BYTE) begin
                  sda_oe <= 1'b0;
               end else if (bit_cnt == MASTER_ACK_SLOT) begin
                  shift <= reg_rdata;
                  sda_oe <= ~reg_rdata[7];
                  reg_addr <= reg_addr + 8'h01;
                  bit_cnt <= 4'h0;
               end else begin
                  shift <= {shift[6:0], 1'b0};
                  sda_oe <= ~shift[6];
               end
            end
         end else if (state != ST_IDLE) begin
            if (scl_rise && bit_cnt < BITS_PER_BYTE) begin
               shift <= {shift[6:0], sda_f};
               bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == BITS_PER_BYTE) begin
               if (!ack_on) begin
                  ack_on <= 1'b1;
                  sda_oe <= 1'b1;
                  case (state)
                     ST_ADDR: begin
                        rw_read <= shift[0];
                        if (shift[7:1] != dev_addr) begin
                           state <= ST_IDLE;
                           ack_on <= 1'b0;
                           sda_oe <= 1'b0;
                        end
                     end
                     ST_PTR: reg_addr <= shift;
                     ST_WDATA: begin
                        reg_wr <= 1'b1;
                        reg_wdata <= shift;
                     end
                     default: ;
                  endcase
               end else begin
                  ack_on <= 1'b0;
                  bit_cnt <= 4'h0;
                  case (state)
                     ST_ADDR: begin
                        if (rw_read) begin
                           state <= ST_RDATA;
                           shift <= reg_rdata;
                           sda_oe <= ~reg_rdata[7];
                           reg_addr <= reg_addr + 8'h01;
                        end else begin
                           state <= ST_PTR;
                           sda_oe <= 1'b0;
                        end
                     end
                     ST_PTR: begin
                        state <= ST_WDATA;
                        sda_oe <= 1'b0;
                     end
                     ST_WDATA: begin
                        reg_addr <= reg_addr + 8'h01;
                        sda_oe <= 1'b0;
                     end
                     default: begin
                        state <= ST_IDLE;
                        sda_oe <= 1'b0;
                     end
                  endcase
               end
            end
         end
      end
   end
endmodule : control_port_slave
`default_nettype wire

// ### design/coax_link_config_regs.sv
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - Writing bit0 one starts self-clearing soft reset
// - Soft reset leaves programmed registers untouched
// - Config bit0 picks strap pins or registers
// - Config bit1 picks transmitter or receiver role
// - Bits 4:3 pick port arrangement
// - Bit6 low with bit5 low (RMII) drives internal reference on test pin
// - Strap source takes uplink rate from pins
// - Register source takes five-bit uplink rate code
// - Established link reports downlink rate code
module coax_link_config_regs
   import coax_cfg_pkg::*;
#(
   parameter logic [2:0] SILICON_REVISION = 3'h2,  // Arbitrary value
   parameter logic [6:0] DEVICE_ADDR = DEFAULT_DEVICE_ADDR
) (
   input wire logic core_clk,                 // Core clock
   input wire logic rstn,                     // Chip reset, active low
   input wire logic scl_in,                   // Control port clock pin
   input wire logic sda_in,                   // Control port data pin level
   output logic sda_out,                      // Control port data drive value
   output logic sda_oe,                       // High while pulling data low
   input wire logic rate_select_pin0,         // Uplink rate strap bit 0
   input wire logic rate_select_pin1,         // Uplink rate strap bit 1
   input wire logic strap_role_pin,           // Role strap
   input wire logic [1:0] strap_port_pins,    // Port arrangement strap
   input wire logic strap_mii_pin,            // Signalling strap
   input wire logic strap_refclk_ext_pin,     // Reference clock source strap
   input wire logic link_up,                  // Downlink established
   input wire logic [4:0] downlink_rate_code, // Downlink rate from modem
   output logic operating_rst_n,              // Reset of operating logic
   output logic role_receiver,                // 1 receiver, 0 transmitter
   output logic [1:0] port_select,            // Port arrangement in use
   output logic mii_full,                     // 1 MII, 0 RMII
   output logic test_pin_refclk_en,           // Drive internal reference on test pin
   output logic [4:0] uplink_rate_code        // Uplink rate in use
);
   logic [1:0] rst_pipe;
   logic rst_sync_n;
   logic reg_wr;
   logic [7:0] reg_addr;
   logic [7:0] reg_wdata;
   logic [7:0] reg_rdata;
   logic soft_reset;
   logic [7:0] soft_cnt;
   logic [7:0] link_config;
   logic [4:0] uplink_rate;
   logic [4:0] downlink_rate;
   logic [6:0] strap_raw;
   logic [6:0] strap;
   logic [2:0] strap_sync [7];
   logic [4:0] strap_rate;
   logic cfg_from_regs;

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) rst_pipe <= 2'h0;
      else rst_pipe <= {rst_pipe[0], 1'b1};
   end
   assign rst_sync_n = rst_pipe[1];

   control_port_slave u_port (
      .core_clk(core_clk),
      .rst_sync_n(rst_sync_n),
      .dev_addr(DEVICE_ADDR),
      .scl_in(scl_in),
      .sda_in(sda_in),
      .sda_out(sda_out),
      .sda_oe(sda_oe),
      .reg_wr(reg_wr),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata)
   );

   // Strap pins: three stages, change taken when the last two agree
   assign strap_raw = {rate_select_pin1, rate_select_pin0, strap_refclk_ext_pin,
                       strap_mii_pin, strap_port_pins, strap_role_pin};
   for (genvar i = 0; i < 7; i++) begin : g_strap
      always_ff @(posedge core_clk or negedge rst_sync_n) begin
         if (!rst_sync_n) begin
            strap_sync[i] <= 3'h0;
            strap[i] <= 1'b0;
         end else begin
            strap_sync[i] <= {strap_sync[i][1:0], strap_raw[i]};
            if (strap_sync[i][1] == strap_sync[i][2]) strap[i] <= strap_sync[i][2];
         end
      end
   end

   always_comb begin
      case (strap[6:5])
         2'h0: strap_rate = RATE_UP_4M;
         2'h1: strap_rate = RATE_UP_3M;
         2'h2: strap_rate = RATE_UP_9M;
         default: strap_rate = RATE_UP_11M;
      endcase
   end

   // Soft reset: bit self-clears after a fixed time; a new write restarts it
   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         soft_reset <= 1'b0;
         soft_cnt <= 8'h00;
      end else if (reg_wr && reg_addr == ADDR_CHIP_RESET && reg_wdata[BIT_SOFT_RESET]) begin
         soft_reset <= 1'b1;
         soft_cnt <= SOFT_RESET_COUNT;
      end else if (soft_reset) begin
         soft_cnt <= soft_cnt - 8'h01;
         if (soft_cnt == 8'h01) soft_reset <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) operating_rst_n <= 1'b0;
      else operating_rst_n <= ~soft_reset;
   end

   // Configuration storage, reset only by chip reset
   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         link_config <= LINK_CONFIG_RESET;
         uplink_rate <= UPLINK_RATE_RESET;
      end else if (reg_wr) begin
         if (reg_addr == ADDR_LINK_CONFIG) link_config <= reg_wdata & LINK_CONFIG_MASK;
         if (reg_addr == ADDR_UPLINK_RATE) uplink_rate <= reg_wdata[4:0];
      end
   end

   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) downlink_rate <= DOWNLINK_RATE_RESET;
      else if (link_up) downlink_rate <= downlink_rate_code;
   end

   always_comb begin
      case (reg_addr)
         ADDR_CHIP_RESET: reg_rdata = {SILICON_REVISION, 4'h0, soft_reset};
         ADDR_LINK_CONFIG: reg_rdata = link_config;
         ADDR_UPLINK_RATE: reg_rdata = {3'h0, uplink_rate};
         ADDR_DOWNLINK_RATE: reg_rdata = {3'h0, downlink_rate};
         default: reg_rdata = 8'h00;
      endcase
   end

   assign cfg_from_regs = link_config[BIT_CFG_SOURCE];

   // Effective configuration: strap pins or registers
   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         role_receiver <= 1'b0;
         port_select <= PORT_A_MAC;
         mii_full <= 1'b1;
         test_pin_refclk_en <= 1'b0;
         uplink_rate_code <= RATE_UP_4M;
      end else if (cfg_from_regs) begin
         role_receiver <= link_config[BIT_ROLE];
         port_select <= link_config[BIT_PORT_LO +: 2];
         mii_full <= link_config[BIT_MII];
         test_pin_refclk_en <= ~link_config[BIT_REFCLK_EXT] & ~link_config[BIT_MII];
         uplink_rate_code <= uplink_rate;
      end else begin
         role_receiver <= strap[0];
         port_select <= strap[2:1];
         mii_full <= strap[3];
         test_pin_refclk_en <= ~strap[4] & ~strap[3];
         uplink_rate_code <= strap_rate;
      end
   end

   property p_soft_self_clear;
      @(posedge core_clk) disable iff (!rst_sync_n)
      (reg_wr && reg_addr == ADDR_CHIP_RESET && reg_wdata[0])
         |=> soft_reset ##[120:126] !soft_reset;
   endproperty
   a_soft_self_clear: assert property (p_soft_self_clear) else $error("soft reset bit stuck");

   property p_soft_keeps_config;
      @(posedge core_clk) disable iff (!rst_sync_n)
      (soft_reset && !reg_wr) |=> $stable(link_config) && $stable(uplink_rate) && !operating_rst_n;
   endproperty
   a_soft_keeps_config: assert property (p_soft_keeps_config) else $error("soft reset lost config");

   property p_strap_source;
      @(posedge core_clk) disable iff (!rst_sync_n)
      !cfg_from_regs |=> role_receiver == $past(strap[0]) && port_select == $past(strap[2:1]);
   endproperty
   a_strap_source: assert property (p_strap_source) else $error("strap config not applied");

   property p_role;
      @(posedge core_clk) disable iff (!rst_sync_n)
      cfg_from_regs |=> role_receiver == $past(link_config[1]);
   endproperty
   a_role: assert property (p_role) else $error("role does not follow register");

   property p_port;
      @(posedge core_clk) disable iff (!rst_sync_n)
      cfg_from_regs |=> port_select == $past(link_config[4:3]);
   endproperty
   a_port: assert property (p_port) else $error("port select wrong");

   property p_mii;
      @(posedge core_clk) disable iff (!rst_sync_n)
      cfg_from_regs |=> mii_full == $past(link_config[5]);
   endproperty
   a_mii: assert property (p_mii) else $error("signalling select wrong");

   property p_refclk;
      @(posedge core_clk) disable iff (!rst_sync_n)
      test_pin_refclk_en |-> !mii_full;
   endproperty
   a_refclk: assert property (p_refclk) else $error("reference driven in MII mode");

   // Internal reference only for RMII with bit 6 clear
   property p_refclk_reg;
      @(posedge core_clk) disable iff (!rst_sync_n)
      cfg_from_regs |=> test_pin_refclk_en == ($past(link_config[6:5]) == 2'h0);
   endproperty
   a_refclk_reg: assert property (p_refclk_reg) else $error("reference pin enable wrong");

   property p_strap_rate;
      @(posedge core_clk) disable iff (!rst_sync_n)
      (!cfg_from_regs && $stable(strap[6:5])) |=> uplink_rate_code == $past(strap_rate);
   endproperty
   a_strap_rate: assert property (p_strap_rate) else $error("uplink rate ignores pins");

   property p_reg_rate;
      @(posedge core_clk) disable iff (!rst_sync_n)
      cfg_from_regs |=> uplink_rate_code == $past(uplink_rate);
   endproperty
   a_reg_rate: assert property (p_reg_rate) else $error("uplink rate ignores register");

   property p_downlink;
      @(posedge core_clk) disable iff (!rst_sync_n)
      link_up |=> downlink_rate == $past(downlink_rate_code);
   endproperty
   a_downlink: assert property (p_downlink) else $error("downlink rate not reported");
endmodule : coax_link_config_regs
`default_nettype wire

// ### verification/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top
   import coax_cfg_pkg::*;
();
   localparam int H = 12;
   localparam logic [2:0] REV = 3'h5;  // Arbitrary value
   logic core_clk, rstn, scl_in, sda_m, sda_in, sda_out, sda_oe;
   logic rate_select_pin0, rate_select_pin1, strap_role_pin, strap_mii_pin;
   logic strap_refclk_ext_pin, link_up, operating_rst_n, role_receiver;
   logic mii_full, test_pin_refclk_en, measuring;
   logic [1:0] strap_port_pins, port_select;
   logic [4:0] downlink_rate_code, uplink_rate_code;
   int miscompares, n_compared, low_cnt;

   // Open-drain data wire: low when either party pulls it
   assign sda_in = sda_m & !sda_oe;

   coax_link_config_regs #(.SILICON_REVISION(REV), .DEVICE_ADDR(DEFAULT_DEVICE_ADDR))
   u_coax_link_config_regs (
      .core_clk(core_clk), .rstn(rstn), .scl_in(scl_in), .sda_in(sda_in),
      .sda_out(sda_out), .sda_oe(sda_oe), .rate_select_pin0(rate_select_pin0),
      .rate_select_pin1(rate_select_pin1), .strap_role_pin(strap_role_pin),
      .strap_port_pins(strap_port_pins), .strap_mii_pin(strap_mii_pin),
      .strap_refclk_ext_pin(strap_refclk_ext_pin), .link_up(link_up),
      .downlink_rate_code(downlink_rate_code), .operating_rst_n(operating_rst_n),
      .role_receiver(role_receiver), .port_select(port_select), .mii_full(mii_full),
      .test_pin_refclk_en(test_pin_refclk_en), .uplink_rate_code(uplink_rate_code)
   );

   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end

   always @(posedge core_clk) begin
      if (measuring && operating_rst_n === 1'b0) low_cnt <= low_cnt + 1;
   end

   function automatic logic [7:0] obs();
      return {3'h0, test_pin_refclk_en, mii_full, port_select, role_receiver};
   endfunction : obs

   task automatic wclk(input int n);
      repeat (n) @(negedge core_clk);
   endtask : wclk

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic finish_test();
      if (miscompares == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : finish_test

   // Start and repeated start: data falls while clock is high
   task automatic bus_start();
      sda_m = 1'b1;
      wclk(H);
      scl_in = 1'b1;
      wclk(H);
      sda_m = 1'b0;
      wclk(H);
      scl_in = 1'b0;
      wclk(3);
   endtask : bus_start

   task automatic bus_stop();
      sda_m = 1'b0;
      wclk(H);
      scl_in = 1'b1;
      wclk(H);
      sda_m = 1'b1;
      wclk(H);
   endtask : bus_stop

   // Data changes only a few cycles after the clock fall, sampled mid-high
   task automatic bus_bit(input logic b, output logic r);
      sda_m = b;
      wclk(H);
      scl_in = 1'b1;
      wclk(H / 2);
      r = sda_in;
      wclk(H / 2);
      scl_in = 1'b0;
      wclk(3);
   endtask : bus_bit

   // For reads d[0] gives the master's acknowledge level (1 ends the read)
   task automatic bus_byte(input logic [7:0] d, input logic rd, output logic [7:0] q,
                           output logic ack_n);
      for (int i = 7; i >= 0; i--) bus_bit(rd ? 1'b1 : d[i], q[i]);
      bus_bit(rd ? d[0] : 1'b1, ack_n);
   endtask : bus_byte

   task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] q;
      logic k0, k1, k2;
      bus_start();
      bus_byte({DEFAULT_DEVICE_ADDR, 1'b0}, 1'b0, q, k0);
      bus_byte(a, 1'b0, q, k1);
      bus_byte(d, 1'b0, q, k2);
      bus_stop();
      check({7'h0, k0 | k1 | k2}, 8'h00);
      check({7'h0, sda_out}, 8'h00);
      wclk(4);
   endtask : reg_write

   task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
      logic [7:0] q;
      logic k0, k1, k2, k3;
      bus_start();
      bus_byte({DEFAULT_DEVICE_ADDR, 1'b0}, 1'b0, q, k0);
      bus_byte(a, 1'b0, q, k1);
      bus_start();
      bus_byte({DEFAULT_DEVICE_ADDR, 1'b1}, 1'b0, q, k2);
      bus_byte(8'h01, 1'b1, d, k3);
      bus_stop();
      check({7'h0, k0 | k1 | k2}, 8'h00);
      wclk(4);
   endtask : reg_read

   task automatic t_reset_values();
      logic [7:0] d, q;
      logic k;
      reg_read(ADDR_LINK_CONFIG, d);
      check(d, 8'h60);
      reg_read(ADDR_UPLINK_RATE, d);
      check(d, 8'h00);
      reg_read(ADDR_DOWNLINK_RATE, d);
      check(d, 8'h00);
      reg_read(ADDR_CHIP_RESET, d);
      check(d, {REV, 5'h00});
      reg_write(8'h05, 8'h5A);
      reg_read(8'h05, d);
      check(d, 8'h00);
      bus_start();
      bus_byte({DEFAULT_DEVICE_ADDR ^ 7'h01, 1'b0}, 1'b0, q, k);
      bus_stop();
      check({7'h0, k}, 8'h01);
   endtask : t_reset_values

   task automatic t_straps();
      logic [7:0] up [4] = '{8'h04, 8'h02, 8'h11, 8'h13};
      for (int i = 0; i < 4; i++) begin
         {rate_select_pin1, rate_select_pin0} = 2'(i);
         strap_role_pin = i[0];
         strap_port_pins = 2'(i % 3);
         strap_mii_pin = i[1];
         strap_refclk_ext_pin = i[0];
         wclk(12);
         check({3'h0, uplink_rate_code}, up[i]);
         check(obs(), {3'h0, !i[1] & !i[0], i[1], 2'(i % 3), i[0]});
      end
   endtask : t_straps

   task automatic t_registers();
      logic [7:0] d;
      logic [7:0] cfg [5] = '{8'h01, 8'h0B, 8'h71, 8'h41, 8'h23};
      logic [7:0] exp [5] = '{8'h10, 8'h13, 8'h0C, 8'h00, 8'h09};
      logic [7:0] rate [4] = '{8'h11, 8'h13, 8'h02, 8'h04};
      {rate_select_pin1, rate_select_pin0} = 2'h0;
      strap_role_pin = 1'b1;
      strap_port_pins = 2'h2;
      strap_mii_pin = 1'b1;
      strap_refclk_ext_pin = 1'b1;
      for (int i = 0; i < 5; i++) begin
         reg_write(ADDR_LINK_CONFIG, cfg[i]);
         check(obs(), exp[i]);
         reg_read(ADDR_LINK_CONFIG, d);
         check(d, cfg[i]);
      end
      for (int i = 0; i < 4; i++) begin
         reg_write(ADDR_UPLINK_RATE, rate[i]);
         check({3'h0, uplink_rate_code}, rate[i]);
      end
   endtask : t_registers

   task automatic t_soft_reset();
      logic [7:0] d;
      low_cnt = 0;
      measuring = 1'b1;
      reg_write(ADDR_CHIP_RESET, 8'h01);
      check({7'h0, operating_rst_n}, 8'h00);
      wclk(SOFT_RESET_CYCLES + 20);
      measuring = 1'b0;
      check({7'h0, operating_rst_n}, 8'h01);
      check({7'h0, low_cnt >= SOFT_RESET_CYCLES - 1 && low_cnt <= SOFT_RESET_CYCLES + 1},
            8'h01);
      reg_read(ADDR_CHIP_RESET, d);
      check(d, {REV, 5'h00});
      reg_read(ADDR_LINK_CONFIG, d);
      check(d, 8'h23);
      reg_read(ADDR_UPLINK_RATE, d);
      check(d, 8'h04);
      check(obs(), 8'h09);
      check({3'h0, uplink_rate_code}, 8'h04);
   endtask : t_soft_reset

   task automatic t_downlink();
      logic [7:0] d;
      logic [4:0] codes [4] = '{5'h0A, 5'h0C, 5'h11, 5'h13};
      link_up = 1'b1;
      for (int i = 0; i < 4; i++) begin
         downlink_rate_code = codes[i];
         wclk(4);
         reg_read(ADDR_DOWNLINK_RATE, d);
         check(d, {3'h0, codes[i]});
      end
      link_up = 1'b0;
      downlink_rate_code = 5'h0C;
      wclk(4);
      reg_read(ADDR_DOWNLINK_RATE, d);
      check(d, 8'h13);
   endtask : t_downlink

   initial begin
      miscompares = 0;
      n_compared = 0;
      low_cnt = 0;
      measuring = 1'b0;
      rstn = 1'b0;
      scl_in = 1'b1;
      sda_m = 1'b1;
      {rate_select_pin1, rate_select_pin0} = 2'h0;
      strap_role_pin = 1'b0;
      strap_port_pins = 2'h0;
      strap_mii_pin = 1'b1;
      strap_refclk_ext_pin = 1'b1;
      link_up = 1'b0;
      downlink_rate_code = 5'h00;
      wclk(12);
      check({7'h0, operating_rst_n}, 8'h00);
      rstn = 1'b1;
      wclk(12);
      t_reset_values();
      t_straps();
      t_registers();
      t_soft_reset();
      t_downlink();
      finish_test();
   end

   initial begin
      #720000;
      miscompares++;
      finish_test();
   end
endmodule : tb_top
`default_nettype wire
